// [design/isp_pkg.sv]
`default_nettype none
package isp_pkg;
    // ==============================================================
    // clock
    localparam int unsigned CLK_PERIOD_NS = 25;

    // ==============================================================
    // register word indices (byte address = 4 * index)
    localparam logic [5:0] IDX_ENTRY_COUNT = 6'h00;
    localparam logic [5:0] IDX_SELECT = 6'h01;
    localparam logic [5:0] IDX_CYCLE = 6'h02;
    localparam logic [5:0] IDX_SHIFT = 6'h03;
    localparam logic [5:0] IDX_CAPABILITY = 6'h04;
    localparam logic [5:0] IDX_MIN_PERIOD = 6'h05;
    localparam logic [5:0] IDX_CALC_COPY = 6'h06;
    localparam logic [5:0] IDX_MEASURE_CTRL = 6'h08;
    localparam logic [5:0] IDX_DELAY = 6'h09;
    localparam logic [5:0] IDX_MISSED = 6'h0B;
    localparam logic [5:0] IDX_OVERRUN = 6'h0C;
    localparam logic [5:0] IDX_GAP_SHORT = 6'h0D;
    localparam logic [5:0] IDX_LATE_SYNC = 6'h20;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h31;

    // ==============================================================
    // reset values
    localparam logic [7:0] ENTRY_COUNT_VAL = 8'h20;
    localparam logic [15:0] SELECT_RST = 16'h0000;
    localparam logic [31:0] TIME_RST = 32'h00000000;
    localparam logic [15:0] CAP_RST = 16'h8007;
    localparam logic [15:0] MEASURE_CTRL_RST = 16'h0000;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    // ==============================================================
    // sync select encodings
    localparam logic [15:0] MODE_FREE_RUN = 16'h0000;
    localparam logic [15:0] MODE_INPUT_EVT = 16'h0001;
    localparam logic [15:0] MODE_FIRST_PULSE = 16'h0002;
    localparam logic [15:0] MODE_SECOND_PULSE = 16'h0003;
    localparam logic [15:0] MODE_OUTPUT_EVT = 16'h0022;

    // ==============================================================
    // capability fields and measure command
    localparam int unsigned CAP_FREE_BIT = 0;
    localparam int unsigned CAP_BUF_BIT = 1;
    localparam int unsigned CAP_DC_LSB = 2;
    localparam int unsigned CAP_SHIFT_LSB = 4;
    localparam int unsigned CAP_DYN_BIT = 14;
    localparam logic [1:0] CAP_DC_VAL = 2'h1;
    localparam logic [15:0] CMD_START = 16'h0001;

    // ==============================================================
    // interrupt bits
    localparam int unsigned IRQ_MISSED = 0;
    localparam int unsigned IRQ_OVERRUN = 1;
    localparam int unsigned IRQ_GAP_SHORT = 2;
    localparam int unsigned IRQ_LATE = 3;
    localparam int unsigned IRQ_W = 4;

    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_CONVERT} isp_state_e;

    // least time: round up to whole cycles
    function automatic logic [31:0] isp_ns_to_cyc(input logic [31:0] ns);
        return 32'(ns / CLK_PERIOD_NS) + 32'((ns % CLK_PERIOD_NS) != 0);
    endfunction : isp_ns_to_cyc

    function automatic logic [31:0] isp_cyc_to_ns(input logic [31:0] cyc);
        return 32'(cyc * CLK_PERIOD_NS);
    endfunction : isp_cyc_to_ns

    function automatic logic [31:0] isp_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : isp_merge

    function automatic logic [31:0] isp_max(input logic [31:0] a, input logic [31:0] b);
        return (a > b) ? a : b;
    endfunction : isp_max
endpackage : isp_pkg
`default_nettype wire

// [design/isp_sat_counter.sv]
`timescale 1ns/100ps
`default_nettype none
module isp_sat_counter #(
    parameter int unsigned CNT_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // count
    input wire logic inc,
    output logic [CNT_W-1:0] value
);
    generate
        if (CNT_W < 1 || CNT_W > 32) begin : g_chk
            $error("isp_sat_counter: CNT_W out of range");
        end
    endgenerate

    // holds at all ones instead of wrapping
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value <= '0;
        end else if (inc && value != {CNT_W{1'b1}}) begin
            value <= value + 1'b1;
        end
    end
endmodule : isp_sat_counter
`default_nettype wire

// [design/isp_interval_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module isp_interval_timer #(
    parameter int unsigned TMR_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // interval marks
    input wire logic start,
    input wire logic stop,
    // result
    output logic done,
    output logic [TMR_W-1:0] elapsed
);
    logic running_q;
    logic [TMR_W-1:0] cnt_q;

    generate
        if (TMR_W < 2 || TMR_W > 32) begin : g_chk
            $error("isp_interval_timer: TMR_W out of range");
        end
    endgenerate

    // counts cycles from start to stop, saturating
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            running_q <= 1'b0;
            cnt_q <= '0;
        end else if (start) begin
            running_q <= 1'b1;
            cnt_q <= '0;
        end else if (running_q) begin
            if (stop) begin
                running_q <= 1'b0;
            end else if (cnt_q != {TMR_W{1'b1}}) begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done <= 1'b0;
            elapsed <= '0;
        end else begin
            done <= running_q && stop && !start;
            if (running_q && stop && !start) begin
                elapsed <= cnt_q + 1'b1;
            end
        end
    end
endmodule : isp_interval_timer
`default_nettype wire

// [design/isp_input_sync.sv]
// How it works
// [RQ1] select codes: 0,1,2,3,34 pick trigger
// [RQ2] cycle period in ns, meaning per mode
// [RQ3] first-pulse mode samples after shift interval
// [RQ4] capability bits 0,1 and 2-3=01
// [RQ5] capability bits 4-5 give shift style
// [RQ6] capability bit 14 flags dynamic times
// [RQ7] command 1 starts, 0 stops measurement
// [RQ8] measuring keeps maxima, cleared at restart
// [RQ9] report sample-to-ready time in ns
// [RQ10] report second-pulse-to-sample time in ns
// [RQ11] count missed buffer events, run and sync
// [RQ12] count late or too-early cycles in run
// [RQ13] count too-short first-to-second pulse gaps
// [RQ14] flag incorrect sync in last cycle
// [RQ15] expose smallest sustainable period in ns
// [RQ16] output and input buffer events as triggers
// [RQ17] counters saturate, zero on reset
`timescale 1ns/100ps
`default_nettype none
module isp_input_sync
    import isp_pkg::*;
#(
    parameter int unsigned CNT_W = 16,
    parameter logic [1:0] CAP_SHIFT_MODE = 2'h0,
    parameter logic CAP_DYNAMIC = 1'b0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // sync and buffer events
    input wire logic first_sync_pulse,
    input wire logic second_sync_pulse,
    input wire logic output_buffer_event,
    input wire logic input_buffer_event,
    input wire logic run_state,
    input wire logic inputs_ready,
    // sampling and interrupt
    output logic sample_strobe,
    output logic irq
);

    generate
        if (CNT_W != 16) begin : g_chk
            $error("isp_input_sync: counters are 16 bits wide");
        end
    endgenerate

    // ==============================================================
    // registers and internal state
    logic [15:0] select_q, cmd_q, cap, missed_cnt, overrun_cnt, short_cnt;
    logic [31:0] cycle_q, shift_q, min_q, calc_q, delay_q, rd_d, shift_cnt_q, free_cnt_q, gap_q;
    logic [31:0] period_cyc, shift_cyc, t_shift_cyc, t_delay_cyc, t_calc_cyc;
    logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, events;
    logic [5:0] idx;
    isp_state_e state_q;
    logic late_q, seen_in_q, seen_out_q, armed_q, access, wr, measuring, restart, dc_mode;
    logic free_hit, direct_fire, shift_fire, fire, early, ev_missed, ev_overrun, ev_short;
    logic ev_late, t_shift_done, t_delay_done, t_calc_done;

    // ==============================================================
    // bus decode
    assign access = wb_cyc && wb_stb && !wb_ack;
    assign wr = access && wb_we;
    assign idx = wb_adr[7:2];
    assign measuring = (cmd_q == CMD_START);
    // a start written while stopped clears earlier maxima
    assign restart = wr && idx == IDX_MEASURE_CTRL && wb_sel[0]
                     && wb_dat_w[15:0] == CMD_START && !measuring; // [RQ8]

    // ==============================================================
    // capability word
    always_comb begin
        cap = CAP_RST;
        cap[CAP_FREE_BIT] = 1'b1; // [RQ4]
        cap[CAP_BUF_BIT] = 1'b1; // [RQ4]
        cap[CAP_DC_LSB +: 2] = CAP_DC_VAL; // [RQ4]
        cap[CAP_SHIFT_LSB +: 2] = CAP_SHIFT_MODE; // [RQ5]
        cap[CAP_DYN_BIT] = CAP_DYNAMIC; // [RQ6]
    end

    // ==============================================================
    // trigger selection
    assign dc_mode = (select_q == MODE_FIRST_PULSE) || (select_q == MODE_SECOND_PULSE);
    assign period_cyc = isp_ns_to_cyc(cycle_q); // [RQ2]
    assign shift_cyc = isp_ns_to_cyc(shift_q); // [RQ3]
    assign free_hit = (cycle_q != TIME_RST) && (free_cnt_q + 32'h1 >= period_cyc);

    always_comb begin
        direct_fire = 1'b0;
        if (select_q == MODE_FREE_RUN) begin
            direct_fire = free_hit; // [RQ1] [RQ2]
        end else if (select_q == MODE_INPUT_EVT) begin
            direct_fire = input_buffer_event; // [RQ1] [RQ16]
        end else if (select_q == MODE_OUTPUT_EVT) begin
            direct_fire = output_buffer_event; // [RQ1] [RQ16]
        end else if (select_q == MODE_FIRST_PULSE) begin
            direct_fire = first_sync_pulse && shift_cyc == 32'h0; // [RQ1] [RQ3]
        end else if (select_q == MODE_SECOND_PULSE) begin
            direct_fire = second_sync_pulse; // [RQ1]
        end
    end

    assign shift_fire = (state_q == ST_SHIFT) && (shift_cnt_q <= 32'h1); // [RQ3]
    assign fire = direct_fire || shift_fire;
    // next trigger before one full period
    assign early = (select_q != MODE_FREE_RUN) && (cycle_q != TIME_RST)
                   && armed_q && (gap_q + 32'h1 < period_cyc);

    // ==============================================================
    // diagnostic events
    assign ev_missed = run_state && dc_mode && first_sync_pulse && armed_q
                       && !seen_in_q && !input_buffer_event; // [RQ11]
    assign ev_overrun = run_state && fire && (state_q == ST_CONVERT || early); // [RQ12]
    assign ev_short = dc_mode && second_sync_pulse && state_q == ST_SHIFT; // [RQ13]
    assign ev_late = dc_mode && first_sync_pulse && armed_q
                     && !seen_out_q && !output_buffer_event; // [RQ14]

    // late, gap short, overrun, missed from bit 3 down
    assign events = {ev_late, ev_short, ev_overrun, ev_missed};

    // ==============================================================
    // sampling sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            shift_cnt_q <= TIME_RST;
        end else begin
            case (state_q)
                ST_SHIFT: begin
                    if (shift_fire) begin
                        state_q <= ST_CONVERT;
                    end else begin
                        shift_cnt_q <= shift_cnt_q - 32'h1;
                    end
                end
                default: begin
                    if (select_q == MODE_FIRST_PULSE && first_sync_pulse
                        && shift_cyc != 32'h0) begin
                        state_q <= ST_SHIFT; // [RQ3]
                        shift_cnt_q <= shift_cyc;
                    end else if (direct_fire) begin
                        state_q <= ST_CONVERT;
                    end else if (state_q == ST_CONVERT && inputs_ready) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // local timer and trigger spacing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            free_cnt_q <= TIME_RST;
            gap_q <= TIME_RST;
        end else begin
            free_cnt_q <= (free_hit || select_q != MODE_FREE_RUN) ? TIME_RST : free_cnt_q + 32'h1;
            if (fire) begin
                gap_q <= TIME_RST;
            end else if (gap_q != 32'hFFFFFFFF) begin
                gap_q <= gap_q + 32'h1;
            end
        end
    end

    // buffer events seen since the last first pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seen_in_q <= 1'b0;
            seen_out_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            if (first_sync_pulse) begin
                seen_in_q <= 1'b0;
                seen_out_q <= 1'b0;
            end else begin
                seen_in_q <= seen_in_q || input_buffer_event;
                seen_out_q <= seen_out_q || output_buffer_event;
            end
            if (dc_mode ? first_sync_pulse : fire) begin
                armed_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= fire;
        end
    end

    // ==============================================================
    // interval timers
    isp_interval_timer #(.TMR_W(32)) u_t_shift (.clk(core_clk), .rst(rst),
        .start(first_sync_pulse), .stop(fire), .done(t_shift_done), .elapsed(t_shift_cyc));
    isp_interval_timer #(.TMR_W(32)) u_t_delay (.clk(core_clk), .rst(rst),
        .start(second_sync_pulse), .stop(fire), .done(t_delay_done), .elapsed(t_delay_cyc));
    isp_interval_timer #(.TMR_W(32)) u_t_calc (.clk(core_clk), .rst(rst),
        .start(fire), .stop(inputs_ready), .done(t_calc_done), .elapsed(t_calc_cyc));

    // ==============================================================
    // diagnostic counters
    isp_sat_counter #(.CNT_W(CNT_W)) u_missed (.clk(core_clk), .rst(rst), .inc(ev_missed), // [RQ11] [RQ17]
        .value(missed_cnt));
    isp_sat_counter #(.CNT_W(CNT_W)) u_overrun (.clk(core_clk), .rst(rst), .inc(ev_overrun), // [RQ12] [RQ17]
        .value(overrun_cnt));
    isp_sat_counter #(.CNT_W(CNT_W)) u_short (.clk(core_clk), .rst(rst), .inc(ev_short), // [RQ13] [RQ17]
        .value(short_cnt));

    // ==============================================================
    // software registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            select_q <= SELECT_RST;
            cycle_q <= TIME_RST;
            cmd_q <= MEASURE_CTRL_RST;
            irq_mask_q <= '0;
        end else if (wr) begin
            if (idx == IDX_SELECT) begin
                select_q <= 16'(isp_merge({16'h0, select_q}, wb_dat_w, wb_sel)); // [RQ1]
            end else if (idx == IDX_CYCLE) begin
                cycle_q <= isp_merge(cycle_q, wb_dat_w, wb_sel); // [RQ2]
            end else if (idx == IDX_MEASURE_CTRL) begin
                cmd_q <= 16'(isp_merge({16'h0, cmd_q}, wb_dat_w, wb_sel)); // [RQ7]
            end else if (idx == IDX_IRQ_MASK) begin
                irq_mask_q <= IRQ_W'(isp_merge({28'h0, irq_mask_q}, wb_dat_w, wb_sel));
            end
        end
    end

    // shift is configured by software and raised by measurement
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shift_q <= TIME_RST;
        end else if (restart) begin
            shift_q <= TIME_RST; // [RQ8]
        end else if (wr && idx == IDX_SHIFT) begin
            shift_q <= isp_merge(shift_q, wb_dat_w, wb_sel); // [RQ3]
        end else if (measuring && t_shift_done && dc_mode) begin
            shift_q <= isp_max(shift_q, isp_cyc_to_ns(t_shift_cyc)); // [RQ8]
        end
    end

    // measured maxima
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            calc_q <= TIME_RST;
            delay_q <= TIME_RST;
            min_q <= TIME_RST;
        end else if (restart) begin
            calc_q <= TIME_RST; // [RQ8]
            delay_q <= TIME_RST; // [RQ8]
            min_q <= TIME_RST;
        end else if (measuring) begin
            if (t_calc_done && dc_mode) begin
                calc_q <= isp_max(calc_q, isp_cyc_to_ns(t_calc_cyc)); // [RQ8] [RQ9]
            end
            if (t_delay_done && dc_mode) begin
                delay_q <= isp_max(delay_q, isp_cyc_to_ns(t_delay_cyc)); // [RQ8] [RQ10]
            end
            if (t_calc_done) begin
                min_q <= isp_max(min_q, isp_cyc_to_ns(t_calc_cyc + 32'h1)); // [RQ15]
            end
        end
    end

    // per-cycle sync verdict, renewed at each first pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            late_q <= 1'b0;
        end else if (!dc_mode) begin
            late_q <= 1'b0;
        end else if (first_sync_pulse && armed_q) begin
            late_q <= ev_late; // [RQ14]
        end
    end

    // ==============================================================
    // interrupts: set wins over write-one-to-clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= '0;
        end else if (wr && idx == IDX_IRQ_STATUS && wb_sel[0]) begin
            irq_stat_q <= (irq_stat_q & ~wb_dat_w[IRQ_W-1:0]) | events;
        end else begin
            irq_stat_q <= irq_stat_q | events;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ==============================================================
    // read mux and acknowledge
    always_comb begin
        rd_d = 32'h0;
        if (idx == IDX_ENTRY_COUNT) begin
            rd_d = {24'h0, ENTRY_COUNT_VAL};
        end else if (idx == IDX_SELECT) begin
            rd_d = {16'h0, select_q};
        end else if (idx == IDX_CYCLE) begin
            rd_d = cycle_q;
        end else if (idx == IDX_SHIFT) begin
            rd_d = shift_q;
        end else if (idx == IDX_CAPABILITY) begin
            rd_d = {16'h0, cap};
        end else if (idx == IDX_MIN_PERIOD) begin
            rd_d = min_q;
        end else if (idx == IDX_CALC_COPY) begin
            rd_d = calc_q;
        end else if (idx == IDX_MEASURE_CTRL) begin
            rd_d = {16'h0, cmd_q};
        end else if (idx == IDX_DELAY) begin
            rd_d = delay_q;
        end else if (idx == IDX_MISSED) begin
            rd_d = {16'h0, missed_cnt};
        end else if (idx == IDX_OVERRUN) begin
            rd_d = {16'h0, overrun_cnt};
        end else if (idx == IDX_GAP_SHORT) begin
            rd_d = {16'h0, short_cnt};
        end else if (idx == IDX_LATE_SYNC) begin
            rd_d = {31'h0, late_q};
        end else if (idx == IDX_IRQ_STATUS) begin
            rd_d = {28'h0, irq_stat_q};
        end else if (idx == IDX_IRQ_MASK) begin
            rd_d = {28'h0, irq_mask_q};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_ack <= 1'b0;
            wb_dat_r <= 32'h0;
        end else begin
            wb_ack <= access;
            if (access && !wb_we) begin
                wb_dat_r <= rd_d;
            end
        end
    end
endmodule : isp_input_sync
`default_nettype wire

// [testbench/isp_master_model.sv]
`timescale 1ns/100ps
`default_nettype none
module isp_master_model (
    // clock
    input wire logic core_clk,
    // pulses towards the slave
    output logic first_sync_pulse,
    output logic second_sync_pulse,
    output logic output_buffer_event,
    output logic input_buffer_event,
    output logic inputs_ready
);
    logic [4:0] p_q = 5'h00;
    // order: ready, input, output, second, first
    assign {inputs_ready, input_buffer_event, output_buffer_event} = p_q[4:2];
    assign {second_sync_pulse, first_sync_pulse} = p_q[1:0];
    // lines change only right after an edge
    task automatic fire(input logic [4:0] m, input int n);
        @(posedge core_clk);
        p_q <= m;
        repeat (n) @(posedge core_clk);
        p_q <= 5'h00;
    endtask : fire
endmodule : isp_master_model
`default_nettype wire

// [testbench/isp_input_sync_props.sv]
`timescale 1ns/100ps
`default_nettype none
module isp_props
    import isp_pkg::*;
(
    // clock, reset and bus
    input wire logic core_clk,
    input wire logic rst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic wb_ack,
    // events and results
    input wire logic first_sync_pulse,
    input wire logic second_sync_pulse,
    input wire logic output_buffer_event,
    input wire logic input_buffer_event,
    input wire logic run_state,
    input wire logic inputs_ready,
    input wire logic sample_strobe,
    input wire logic irq
);
    // ==========
    // select as last written
    logic [15:0] md_q;
    wire logic req = wb_cyc && wb_stb && !wb_ack;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) md_q <= SELECT_RST;
        else if (req && wb_we && wb_adr[7:2] == IDX_SELECT) md_q <= wb_dat_w[15:0];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_ack_answer: assert property (req |=> wb_ack) else $error("no ack");
    a_ack_pulse: assert property (wb_ack |=> !wb_ack) else $error("ack too long");
    a_rdata_hold: assert property (!$past(req && !wb_we) |-> $stable(wb_dat_r))
        else $error("read data moved");
    a_cap_read: assert property (req && !wb_we && wb_adr[7:2] == IDX_CAPABILITY
        |=> wb_dat_r == 32'h00008007) else $error("bad capability");
    a_late_width: assert property (req && !wb_we && wb_adr[7:2] == IDX_LATE_SYNC
        |=> wb_dat_r[31:1] == 31'h0) else $error("flag too wide");
    a_in_trig: assert property (md_q == MODE_INPUT_EVT && input_buffer_event
        |=> sample_strobe) else $error("no input event sample");
    a_out_trig: assert property (md_q == MODE_OUTPUT_EVT && output_buffer_event
        |=> sample_strobe) else $error("no output event sample");
    a_second_trig: assert property (md_q == MODE_SECOND_PULSE && second_sync_pulse
        |=> sample_strobe) else $error("no second pulse sample");
    c_free: cover property (md_q == MODE_FREE_RUN && sample_strobe);
    c_dc: cover property (md_q == MODE_FIRST_PULSE && sample_strobe);
    c_irq: cover property (irq);
endmodule : isp_props
bind isp_input_sync isp_props u_props (.*);
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
    import isp_pkg::*;
    typedef struct {logic [5:0] ix; logic [31:0] d; logic [31:0] e;} isp_row_s;
    logic core_clk = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, run_state = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat_w = 32'h0, wb_dat_r, cyc = 32'h0, st_t = 32'h0, st_p = 32'h0;
    logic [31:0] n_st = 32'h0, t0, q;
    logic wb_ack, sample_strobe, irq, fsp, ssp, obe, ibe, rdy;
    int failures = 0, checked = 0;
    // nonzero d means write first
    isp_row_s rows [17] = '{'{IDX_ENTRY_COUNT, 0, 32'h20}, '{IDX_SELECT, 0, 0}, '{IDX_CYCLE, 0, 0},
        '{IDX_SHIFT, 0, 0}, '{IDX_CAPABILITY, 0, 32'h8007}, '{IDX_MIN_PERIOD, 0, 0},
        '{IDX_CALC_COPY, 0, 0}, '{IDX_DELAY, 0, 0}, '{IDX_MISSED, 0, 0}, '{IDX_OVERRUN, 0, 0},
        '{IDX_GAP_SHORT, 0, 0}, '{IDX_LATE_SYNC, 0, 0}, '{IDX_SELECT, 32'hFFFF0022, 32'h22},
        '{IDX_CYCLE, 32'hA5A55A5A, 32'hA5A55A5A}, '{IDX_CAPABILITY, 32'hFFFF, 32'h8007},
        '{6'h07, 32'hFFFFFFFF, 0}, '{IDX_MEASURE_CTRL, 32'h1, 32'h1}};
    logic [15:0] md [4] = '{MODE_INPUT_EVT, MODE_SECOND_PULSE, MODE_OUTPUT_EVT, 16'h0005};
    logic [4:0] mk [4] = '{5'h08, 5'h02, 5'h04, 5'h0F};
    always #(CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;
    isp_input_sync uut (.core_clk(core_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .first_sync_pulse(fsp), .second_sync_pulse(ssp), .output_buffer_event(obe),
        .input_buffer_event(ibe), .run_state(run_state), .inputs_ready(rdy),
        .sample_strobe(sample_strobe), .irq(irq));
    isp_master_model mst (.core_clk(core_clk), .first_sync_pulse(fsp), .second_sync_pulse(ssp),
        .output_buffer_event(obe), .input_buffer_event(ibe), .inputs_ready(rdy));
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (sample_strobe === 1'b1) begin
            {st_t, st_p, n_st} <= {cyc, st_t, n_st + 32'h1};
        end
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [5:0] ix, input logic [31:0] d);
        @(posedge core_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, we, ix, 2'b00, d};
        @(posedge core_clk iff wb_ack === 1'b1);
        q = wb_dat_r;
        {wb_cyc, wb_stb} <= 2'b00;
    endtask : wb
    task automatic rd(input logic [5:0] ix, input logic [31:0] e);
        wb(1'b0, ix, 32'h0);
        chk($sformatf("reg %h", ix), e, q);
    endtask : rd
    task automatic final_report();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].d != 0) wb(1'b1, rows[i].ix, rows[i].d);
            rd(rows[i].ix, rows[i].e);
        end
        wb(1'b1, IDX_CYCLE, 32'd100);
        wb(1'b1, IDX_SELECT, 32'(MODE_FREE_RUN));
        repeat (12) @(posedge core_clk);
        chk("free gap", 32'd4, st_t - st_p);
        wb(1'b1, IDX_SHIFT, 32'd50);
        wb(1'b1, IDX_SELECT, 32'(MODE_FIRST_PULSE));
        mst.fire(5'h01, 1);
        t0 = cyc;
        repeat (6) @(posedge core_clk);
        chk("shift delay", 32'd3, st_t - t0);
        foreach (md[i]) begin
            wb(1'b1, IDX_SELECT, 32'(md[i]));
            t0 = n_st;
            mst.fire(mk[i], 1);
            repeat (3) @(posedge core_clk);
            chk($sformatf("mode %h", md[i]), t0 + 32'(i < 3), n_st);
        end
        mst.fire(5'h10, 1);
        wb(1'b1, IDX_CYCLE, 32'h0);
        wb(1'b1, IDX_SELECT, 32'(MODE_INPUT_EVT));
        run_state <= 1'b1;
        mst.fire(5'h08, 1);
        mst.fire(5'h08, 1);
        rd(IDX_OVERRUN, 32'h1);
        chk("irq masked", 32'h0, irq);
        wb(1'b1, IDX_IRQ_MASK, 32'h2);
        @(posedge core_clk);
        chk("irq raised", 32'h1, irq);
        wb(1'b1, IDX_IRQ_STATUS, 32'h2);
        @(posedge core_clk);
        chk("irq cleared", 32'h0, irq);
        mst.fire(5'h08, 65600);
        rd(IDX_OVERRUN, 32'hFFFF);
        wb(1'b1, IDX_SHIFT, 32'h0);
        wb(1'b1, IDX_SELECT, 32'(MODE_FIRST_PULSE));
        mst.fire(5'h01, 1);
        mst.fire(5'h01, 1);
        rd(IDX_MISSED, 32'h1);
        rd(IDX_LATE_SYNC, 32'h1);
        mst.fire(5'h04, 1);
        mst.fire(5'h01, 1);
        rd(IDX_LATE_SYNC, 32'h0);
        wb(1'b1, IDX_SHIFT, 32'd100);
        mst.fire(5'h01, 1);
        mst.fire(5'h02, 1);
        rd(IDX_GAP_SHORT, 32'h1);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        rd(IDX_OVERRUN, 32'h0);
        final_report();
    end
    initial begin
        repeat (80000) @(posedge core_clk);
        failures++;
        final_report();
    end
endmodule : tb
`default_nettype wire
